// ---- rtl/cell_limit_config_decoder.sv ----
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - series code 010..110 gives eight down to four cells
// - high trip 2.8 V plus 25 mV per code
// - high hysteresis 300 mV falling, then 25, 0
// - high delay 0.5 s plus 0.25 s per code
// - thermistor line pulled low on high fault
// - low recovery hysteresis skipped when inhibit set
// - low trip 1.4 V plus 0.1 V per code
// - series code sits in bits 7..5, index 1
module cell_limit_config_decoder #(
  parameter int CELL_MAX = cell_limit_pkg::CELL_MAX,
  parameter int MV_W = cell_limit_pkg::MV_W,
  parameter int TICK_CYCLES = cell_limit_pkg::QUARTER_SEC_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cell measurements
  input wire logic [CELL_MAX*MV_W-1:0] cellMv,
  input wire logic [MV_W-1:0] lowCellHystMv,
  // decoded settings
  output logic [cell_limit_pkg::CNT_W-1:0] cellCount,
  output logic [MV_W-1:0] highCellTripMv,
  output logic [MV_W-1:0] highCellHystMv,
  output logic [cell_limit_pkg::CNT_W-1:0] highCellDelayQuarters,
  output logic [MV_W-1:0] lowCellTripMv,
  // faults
  output wire logic highCellFault,
  output logic lowCellFault,
  // thermistor line, open drain
  output logic thermLineOut,
  output logic thermLineOe,
  // interrupt
  output logic irq
);
  localparam int CW = cell_limit_pkg::CNT_W;
  localparam int EW = cell_limit_pkg::EV_W;

  // stored configuration bytes
  logic [7:0] sysCfg_q;
  logic [7:0] highTrip_q;
  logic [7:0] highCtrl_q;
  logic [7:0] lowTrip_q;
  // interrupt state
  logic [EW-1:0] irqStatus_q;
  logic [EW-1:0] irqMask_q;
  logic [EW-1:0] irqStatus_d;
  // edge history of the high fault
  logic highFaultPrev_q;

  // bus decode, one access answered per request
  wire [5:0] regIdx = wb_adr_i[7:2];
  wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // only lane 0 carries configuration bytes
  wire wrLane0 = busReq && wb_we_i && wb_sel_i[0];
  wire wrSys = wrLane0 && regIdx == cell_limit_pkg::IDX_SYSTEM_CONFIGURATION_REGISTER;
  wire wrHighTrip = wrLane0 && regIdx == cell_limit_pkg::IDX_HIGH_TRIP;
  wire wrHighCtrl = wrLane0 && regIdx == cell_limit_pkg::IDX_HIGH_CTRL;
  wire wrLowTrip = wrLane0 && regIdx == cell_limit_pkg::IDX_LOW_TRIP;
  wire wrStatus = wrLane0 && regIdx == cell_limit_pkg::IDX_IRQ_STATUS;
  wire wrMask = wrLane0 && regIdx == cell_limit_pkg::IDX_IRQ_MASK;

  // field views
  wire [2:0] seriesCellCountCode = sysCfg_q[cell_limit_pkg::CNT_MSB:cell_limit_pkg::CNT_LSB];
  wire [5:0] highCellTripCode = highTrip_q[cell_limit_pkg::TRIP_MSB:0];
  wire chargerInhibitViaThermistor = highCtrl_q[cell_limit_pkg::THERM_BIT];
  wire [2:0] highCellHysteresisCode = highCtrl_q[cell_limit_pkg::HYST_MSB:cell_limit_pkg::HYST_LSB];
  wire [2:0] highCellDelayCode = highCtrl_q[cell_limit_pkg::DELAY_MSB:0];
  wire lowCellRecoveryHysteresisInhibit = lowTrip_q[cell_limit_pkg::LOW_INH_BIT];
  wire [3:0] lowCellTripCode = lowTrip_q[cell_limit_pkg::LOW_TRIP_MSB:0];

  // series count, forbidden codes monitor no cell at all
  wire countValid = seriesCellCountCode >= cell_limit_pkg::CODE_MIN
    && seriesCellCountCode <= cell_limit_pkg::CODE_MAX;
  wire [CW-1:0] countDec = countValid
    ? cell_limit_pkg::CELL_CODE_OFFSET - {1'b0, seriesCellCountCode} : '0;
  // a write that would leave a forbidden code is flagged
  wire [2:0] newCode = wb_dat_i[cell_limit_pkg::CNT_MSB:cell_limit_pkg::CNT_LSB];
  wire badCountWrite = wrSys
    && (newCode < cell_limit_pkg::CODE_MIN || newCode > cell_limit_pkg::CODE_MAX);

  // linear high trip
  wire [MV_W-1:0] tripDec = cell_limit_pkg::TRIP_BASE_MV
    + cell_limit_pkg::TRIP_STEP_MV * MV_W'(highCellTripCode);
  // hysteresis, linear steps then a fine code and a zero code
  wire [MV_W-1:0] hystLinear = cell_limit_pkg::HYST_START_MV
    - cell_limit_pkg::HYST_STEP_MV * MV_W'(highCellHysteresisCode);
  wire [MV_W-1:0] hystDec =
    highCellHysteresisCode == cell_limit_pkg::HYST_ZERO_CODE ? '0
    : highCellHysteresisCode == cell_limit_pkg::HYST_FINE_CODE ? cell_limit_pkg::HYST_FINE_MV
    : hystLinear;
  // delay in quarter seconds
  wire [CW-1:0] delayDec = cell_limit_pkg::DELAY_BASE_Q + CW'(highCellDelayCode);
  // linear low trip
  wire [MV_W-1:0] lowTripDec = cell_limit_pkg::LOW_BASE_MV
    + cell_limit_pkg::LOW_STEP_MV * MV_W'(lowCellTripCode);

  // low recovery level, hysteresis dropped when inhibited
  wire [MV_W-1:0] lowRecoverMv = lowCellRecoveryHysteresisInhibit
    ? lowCellTripMv : lowCellTripMv + lowCellHystMv;
  logic [CELL_MAX-1:0] lowBelowVec;
  logic [CELL_MAX-1:0] lowRecoveredVec;

  // per cell low compare against the registered levels
  for (genvar i = 0; i < CELL_MAX; i++)
  begin : g_low
    wire inUse = CW'(i) < cellCount;
    wire [MV_W-1:0] mv = cellMv[i*MV_W +: MV_W];
    assign lowBelowVec[i] = inUse && (mv < lowCellTripMv);
    assign lowRecoveredVec[i] = !inUse || (mv >= lowRecoverMv);
  end

  wire anyLow = |lowBelowVec;
  wire allRecovered = &lowRecoveredVec;
  wire lowFaultSet = !lowCellFault && anyLow;

  // events into sticky status
  wire [EW-1:0] events = {badCountWrite, lowFaultSet,
    highFaultPrev_q && !highCellFault, !highFaultPrev_q && highCellFault};
  // a set arriving with its clear still wins
  assign irqStatus_d = (irqStatus_q & ~(wrStatus ? wb_dat_i[EW-1:0] : '0)) | events;

  // read mux, reserved bits already held at zero
  wire [7:0] faultState = {5'h00, thermLineOe, lowCellFault, highCellFault};
  wire [7:0] rdByte =
    regIdx == cell_limit_pkg::IDX_SYSTEM_CONFIGURATION_REGISTER ? sysCfg_q
    : regIdx == cell_limit_pkg::IDX_HIGH_TRIP ? highTrip_q
    : regIdx == cell_limit_pkg::IDX_HIGH_CTRL ? highCtrl_q
    : regIdx == cell_limit_pkg::IDX_LOW_TRIP ? lowTrip_q
    : regIdx == cell_limit_pkg::IDX_IRQ_STATUS ? 8'(irqStatus_q)
    : regIdx == cell_limit_pkg::IDX_IRQ_MASK ? 8'(irqMask_q)
    : regIdx == cell_limit_pkg::IDX_FAULT_STATE ? faultState
    : 8'h00; // unmapped reads zero, still acked

  // bus answer one cycle after the request
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? {24'h000000, rdByte} : '0;
    end
  end

  // configuration storage, reserved positions masked off
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sysCfg_q <= cell_limit_pkg::SYSTEM_CONFIGURATION_REGISTER_RST;
      highTrip_q <= cell_limit_pkg::HIGH_TRIP_RST;
      highCtrl_q <= cell_limit_pkg::HIGH_CTRL_RST;
      lowTrip_q <= cell_limit_pkg::LOW_TRIP_RST;
    end
    else
    begin
      if (wrSys)
        sysCfg_q <= wb_dat_i[7:0] & cell_limit_pkg::SYSTEM_CONFIGURATION_REGISTER_MASK;
      if (wrHighTrip)
        highTrip_q <= wb_dat_i[7:0] & cell_limit_pkg::HIGH_TRIP_MASK;
      if (wrHighCtrl)
        highCtrl_q <= wb_dat_i[7:0] & cell_limit_pkg::HIGH_CTRL_MASK;
      if (wrLowTrip)
        lowTrip_q <= wb_dat_i[7:0] & cell_limit_pkg::LOW_TRIP_MASK;
    end
  end

  // decoded settings registered so outputs come from flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cellCount <= '0;
      highCellTripMv <= '0;
      highCellHystMv <= '0;
      highCellDelayQuarters <= '0;
      lowCellTripMv <= '0;
    end
    else
    begin
      cellCount <= countDec;
      highCellTripMv <= tripDec;
      highCellHystMv <= hystDec;
      highCellDelayQuarters <= delayDec;
      lowCellTripMv <= lowTripDec;
    end
  end

  // low fault, no delay here; qualification lives elsewhere
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      lowCellFault <= 1'b0;
    else if (lowFaultSet)
      lowCellFault <= 1'b1;
    else if (allRecovered)
      lowCellFault <= 1'b0;
  end

  // thermistor pulled low only while the option is on
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      thermLineOut <= 1'b0;
      thermLineOe <= 1'b0;
    end
    else
    begin
      thermLineOut <= 1'b0;
      thermLineOe <= chargerInhibitViaThermistor && highCellFault;
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqStatus_q <= '0;
      irqMask_q <= '0;
      highFaultPrev_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      irqStatus_q <= irqStatus_d;
      highFaultPrev_q <= highCellFault;
      if (wrMask)
        irqMask_q <= wb_dat_i[EW-1:0];
      irq <= |(irqStatus_d & (wrMask ? wb_dat_i[EW-1:0] : irqMask_q));
    end
  end

  // qualification timer and hysteresis release
  high_cell_detector #(
    .CELL_MAX(CELL_MAX),
    .MV_W(MV_W),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_detector (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cellMv(cellMv),
    .cellCount(cellCount),
    .tripMv(highCellTripMv),
    .hystMv(highCellHystMv),
    .delayQuarters(highCellDelayQuarters),
    .fault_q(highCellFault)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence sSysWrite;
    wrSys;
  endsequence
  sequence sLowReady;
    lowCellFault && !anyLow && allRecovered;
  endsequence
  sequence sTripRead;
    busReq && !wb_we_i && regIdx == cell_limit_pkg::IDX_HIGH_TRIP;
  endsequence

  chk_count_decode: assert property (seriesCellCountCode == 3'h2 ##1 seriesCellCountCode == 3'h2 |=> cellCount == 4'h8)
    else $error("code 010 did not give eight cells");
  chk_trip_top: assert property (highCellTripCode == 6'h3f |=> highCellTripMv == 16'h1117)
    else $error("top trip code not 4.375 V");
  chk_hyst_fine: assert property (highCellHysteresisCode == 3'h6 |=> highCellHystMv == 16'h0019)
    else $error("hysteresis code 110 not 25 mV");
  chk_delay_top: assert property (highCellDelayCode == 3'h7 |=> highCellDelayQuarters == 4'h9)
    else $error("delay code 111 not 2.25 s");
  chk_therm_pull: assert property (highCellFault |=> thermLineOe == $past(chargerInhibitViaThermistor))
    else $error("thermistor drive does not follow option");
  chk_therm_idle: assert property (!highCellFault |=> !thermLineOe)
    else $error("thermistor driven without high cell fault");
  chk_low_recover: assert property (sLowReady |=> !lowCellFault)
    else $error("low fault held after recovery level");
  chk_low_trip_top: assert property (lowCellTripCode == 4'hf |=> lowCellTripMv == 16'h0b54)
    else $error("top low trip code not 2.9 V");
  chk_cnf_field: assert property (sSysWrite |=> seriesCellCountCode == $past(newCode))
    else $error("series code not taken from bits 7..5");
  chk_rsvd_zero: assert property (sTripRead |=> wb_ack_o && wb_dat_o[7:6] == 2'h0)
    else $error("reserved trip bits read back nonzero");
endmodule // cell_limit_config_decoder
`default_nettype wire

// ---- rtl/cell_limit_pkg.sv ----
`default_nettype none
package cell_limit_pkg;
  // geometry
  localparam int CELL_MAX = 8;
  localparam int MV_W = 16;
  localparam int CNT_W = 4;
  localparam int EV_W = 4;

  // register indexes, byte address is index times four
  localparam logic [5:0] IDX_SYSTEM_CONFIGURATION_REGISTER = 6'h01;
  localparam logic [5:0] IDX_HIGH_TRIP = 6'h02;
  localparam logic [5:0] IDX_HIGH_CTRL = 6'h03;
  localparam logic [5:0] IDX_LOW_TRIP = 6'h04;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
  localparam logic [5:0] IDX_FAULT_STATE = 6'h12;

  // writable bits, reserved positions are held at zero
  localparam logic [7:0] SYSTEM_CONFIGURATION_REGISTER_MASK = 8'hff;
  localparam logic [7:0] HIGH_TRIP_MASK = 8'h3f;
  localparam logic [7:0] HIGH_CTRL_MASK = 8'hf7;
  localparam logic [7:0] LOW_TRIP_MASK = 8'h8f;

  // reset values
  localparam logic [7:0] SYSTEM_CONFIGURATION_REGISTER_RST = 8'h40;
  localparam logic [7:0] HIGH_TRIP_RST = 8'h38;
  localparam logic [7:0] HIGH_CTRL_RST = 8'h00;
  localparam logic [7:0] LOW_TRIP_RST = 8'h06;

  // field positions
  localparam int CNT_MSB = 7;
  localparam int CNT_LSB = 5;
  localparam int TRIP_MSB = 5;
  localparam int THERM_BIT = 7;
  localparam int HYST_MSB = 6;
  localparam int HYST_LSB = 4;
  localparam int DELAY_MSB = 2;
  localparam int LOW_INH_BIT = 7;
  localparam int LOW_TRIP_MSB = 3;

  // series count code
  localparam logic [2:0] CODE_MIN = 3'h2;
  localparam logic [2:0] CODE_MAX = 3'h6;
  localparam logic [3:0] CELL_CODE_OFFSET = 4'ha;

  // thresholds in millivolts
  localparam logic [MV_W-1:0] TRIP_BASE_MV = 16'h0af0;
  localparam logic [MV_W-1:0] TRIP_STEP_MV = 16'h0019;
  localparam logic [MV_W-1:0] HYST_START_MV = 16'h012c;
  localparam logic [MV_W-1:0] HYST_STEP_MV = 16'h0032;
  localparam logic [MV_W-1:0] HYST_FINE_MV = 16'h0019;
  localparam logic [2:0] HYST_FINE_CODE = 3'h6;
  localparam logic [2:0] HYST_ZERO_CODE = 3'h7;
  localparam logic [MV_W-1:0] LOW_BASE_MV = 16'h0578;
  localparam logic [MV_W-1:0] LOW_STEP_MV = 16'h0064;

  // delay timing
  localparam int CLK_HZ = 200_000_000;
  localparam int DELAY_BASE_MS = 500;
  localparam int DELAY_STEP_MS = 250;
  localparam int QUARTER_SEC_CYCLES = (CLK_HZ / 1000) * DELAY_STEP_MS;
  localparam logic [CNT_W-1:0] DELAY_BASE_Q = CNT_W'(DELAY_BASE_MS / DELAY_STEP_MS);

  // interrupt event bits
  localparam int EV_HIGH_SET = 0;
  localparam int EV_HIGH_CLR = 1;
  localparam int EV_LOW_SET = 2;
  localparam int EV_BAD_CNT = 3;

  // qualification state
  typedef enum logic [1:0] {DET_IDLE, DET_QUALIFY, DET_TRIPPED} det_state_type;
endpackage
`default_nettype wire

// ---- rtl/high_cell_detector.sv ----
`timescale 1ns/1ps
`default_nettype none
module high_cell_detector #(
  parameter int CELL_MAX = cell_limit_pkg::CELL_MAX,
  parameter int MV_W = cell_limit_pkg::MV_W,
  parameter int TICK_CYCLES = cell_limit_pkg::QUARTER_SEC_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // measurements and settings
  input wire logic [CELL_MAX*MV_W-1:0] cellMv,
  input wire logic [cell_limit_pkg::CNT_W-1:0] cellCount,
  input wire logic [MV_W-1:0] tripMv,
  input wire logic [MV_W-1:0] hystMv,
  input wire logic [cell_limit_pkg::CNT_W-1:0] delayQuarters,
  // result
  output logic fault_q
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int CW = cell_limit_pkg::CNT_W;

  // hysteresis never exceeds the lowest trip, so no wrap
  wire [MV_W-1:0] releaseMv = tripMv - hystMv;
  logic [CELL_MAX-1:0] aboveVec;
  logic [CELL_MAX-1:0] belowVec;

  // per cell compare, unconfigured cells never trip or hold
  for (genvar i = 0; i < CELL_MAX; i++)
  begin : g_cell
    wire inUse = CW'(i) < cellCount;
    wire [MV_W-1:0] mv = cellMv[i*MV_W +: MV_W];
    assign aboveVec[i] = inUse && (mv > tripMv);
    assign belowVec[i] = !inUse || (mv < releaseMv);
  end

  wire anyAbove = |aboveVec;
  wire allBelow = &belowVec;

  cell_limit_pkg::det_state_type state_q;
  cell_limit_pkg::det_state_type state_d;
  logic [DIV_W-1:0] divCnt_q;
  logic [CW-1:0] qtrCnt_q;
  wire tick = divCnt_q == DIV_W'(TICK_CYCLES - 1);
  wire done = tick && (qtrCnt_q == delayQuarters - CW'(1));

  // fault only after the whole delay with a cell still high
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      cell_limit_pkg::DET_IDLE:
        if (anyAbove)
          state_d = cell_limit_pkg::DET_QUALIFY;
      cell_limit_pkg::DET_QUALIFY:
        if (!anyAbove)
          state_d = cell_limit_pkg::DET_IDLE;
        else if (done)
          state_d = cell_limit_pkg::DET_TRIPPED;
      cell_limit_pkg::DET_TRIPPED:
        if (allBelow)
          state_d = cell_limit_pkg::DET_IDLE;
      default:
        state_d = cell_limit_pkg::DET_IDLE;
    endcase
  end

  // divider restarts with each qualification so the delay is exact
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= cell_limit_pkg::DET_IDLE;
      divCnt_q <= '0;
      qtrCnt_q <= '0;
      fault_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      fault_q <= state_d == cell_limit_pkg::DET_TRIPPED;
      divCnt_q <= (state_q != cell_limit_pkg::DET_QUALIFY || tick) ? '0 : divCnt_q + DIV_W'(1);
      qtrCnt_q <= state_q != cell_limit_pkg::DET_QUALIFY ? '0 : qtrCnt_q + CW'(tick);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_fault_after_delay: assert property ($rose(fault_q) |-> $past(qtrCnt_q) == delayQuarters - CW'(1) && $past(anyAbove))
    else $error("high cell fault raised before delay ran out");
  chk_fault_release: assert property (fault_q && allBelow |=> !fault_q)
    else $error("high cell fault held with all cells below release");
endmodule // high_cell_detector
`default_nettype wire

// ---- tb/cell_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cell_source_model #(
  parameter int CELL_MAX = 8,
  parameter int MV_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // level update from the bench
  input wire logic setEn,
  input wire logic [2:0] setIdx,
  input wire logic [MV_W-1:0] setMv,
  // sampled cell levels
  output logic [CELL_MAX*MV_W-1:0] cellMv
);
  // levels move only on the clock, like a sampled front end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // mid level, above every low trip point and below the reset high trip
      cellMv <= {CELL_MAX{16'h0bb8}};
    end
    else if (setEn)
    begin
      cellMv[setIdx*MV_W +: MV_W] <= setMv;
    end
  end
endmodule // cell_source_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s exp %0h got %0h", nm, (e), (g)); end end
module testbench;
  // stimulus
  logic ref_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [15:0] lowHyst = 16'h0190;
  logic setEn = 1'b0;
  logic [2:0] setIdx = 3'h0;
  logic [15:0] setMv = 16'h0000;
  // observed
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, highCellFault, lowCellFault, thermLineOut, thermLineOe, irq;
  wire logic [127:0] cellMv;
  wire logic [3:0] cellCount, highCellDelayQuarters;
  wire logic [15:0] highCellTripMv, highCellHystMv, lowCellTripMv;
  // bookkeeping
  int num_errors = 0, samples_checked = 0, cycles = 0;
  logic [31:0] expQ[$];
  logic [31:0] expRd;
  logic [7:0] rnd = 8'h04, b;

  always #2.5 ref_clk = ~ref_clk;

  // short tick keeps the qualification delay a few cycles long
  cell_limit_config_decoder #(.TICK_CYCLES(4)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cellMv(cellMv), .lowCellHystMv(lowHyst), .cellCount(cellCount),
    .highCellTripMv(highCellTripMv), .highCellHystMv(highCellHystMv),
    .highCellDelayQuarters(highCellDelayQuarters), .lowCellTripMv(lowCellTripMv),
    .highCellFault(highCellFault), .lowCellFault(lowCellFault),
    .thermLineOut(thermLineOut), .thermLineOe(thermLineOe), .irq(irq));
  cell_source_model i_cells (.ref_clk(ref_clk), .nrst(nrst), .setEn(setEn),
    .setIdx(setIdx), .setMv(setMv), .cellMv(cellMv));

  // pseudo random bytes
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    input logic [31:0] e);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    if (!we)
      expQ.push_back(e);
    // no answer time assumed; only the hang guard ends a lost ack
    do
    begin
      @(posedge ref_clk);
    end
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic setCell(input logic [2:0] i, input logic [15:0] mv);
    @(posedge ref_clk);
    setEn <= 1'b1;
    setIdx <= i;
    setMv <= mv;
    @(posedge ref_clk);
    setEn <= 1'b0;
  endtask

  // bounded wait for the fault level
  task automatic waitFault(input logic v);
    int n;
    n = 0;
    while (highCellFault !== v && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("fault level", v, highCellFault)
  endtask

  // read data checked against the oldest note
  always @(posedge ref_clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      expRd = expQ.pop_front();
      `CHK("read data", expRd, wb_dat_o)
    end
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  initial
  begin
    cyc(6);
    nrst <= 1'b1;
    rd(8'h04, 32'h40);
    rd(8'h08, 32'h38);
    rd(8'h0c, 32'h00);
    rd(8'h10, 32'h06);
    rd(8'hfc, 32'h00);
    `CHK("count", 4'h8, cellCount)
    `CHK("trip", 16'h1068, highCellTripMv)
    `CHK("hyst", 16'h012c, highCellHystMv)
    `CHK("delay", 4'h2, highCellDelayQuarters)
    `CHK("low trip", 16'h07d0, lowCellTripMv)
    // every count code, forbidden ones included
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h04, 8'(i << 5));
      cyc(1);
      `CHK("count", (i >= 2 && i <= 6) ? 4'(10 - i) : 4'h0, cellCount)
      rd(8'h04, 32'(i << 5));
    end
    rd(8'h40, 32'h08);
    wr(8'h40, 8'h08);
    rd(8'h40, 32'h00);
    wr(8'h04, 8'h40);
    // trip codes: both ends, then six random, the third and fourth with reserved bits set
    for (int i = 0; i < 8; i++)
    begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd;
      rnd = lfsr(rnd);
      wr(8'h08, b);
      cyc(1);
      `CHK("trip", 16'h0af0 + 16'h0019 * b[5:0], highCellTripMv)
      rd(8'h08, {26'h0, b[5:0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h0c, {1'b0, 3'(i), 1'b1, 3'(i)});
      cyc(1);
      `CHK("hyst", (i < 6) ? 16'h012c - 16'h0032 * i : (i == 6) ? 16'h0019 : 16'h0000,
           highCellHystMv)
      `CHK("delay", 4'(i + 2), highCellDelayQuarters)
      rd(8'h0c, {25'h0, 3'(i), 1'b0, 3'(i)});
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h10, {4'h7, 4'(i)});
      cyc(1);
      `CHK("low trip", 16'h0578 + 16'h0064 * i, lowCellTripMv)
      rd(8'h10, 32'(i));
    end
    wr(8'h08, 8'h38);
    wr(8'h10, 8'h06);
    wr(8'h44, 8'h01);
    // high fault with and without the thermistor option, two quarter delay
    for (int opt = 0; opt < 2; opt++)
    begin
      wr(8'h0c, {1'(opt), 7'h00});
      setCell(3'h7, 16'h1069);
      cyc(7);
      `CHK("early fault", 1'b0, highCellFault)
      waitFault(1'b1);
      cyc(2);
      `CHK("therm oe", 1'(opt), thermLineOe)
      `CHK("therm out", 1'b0, thermLineOut)
      rd(8'h48, {29'h0, 1'(opt), 2'h1});
      setCell(3'h7, 16'h0f3d);
      cyc(10);
      `CHK("held fault", 1'b1, highCellFault)
      setCell(3'h7, 16'h0f3b);
      waitFault(1'b0);
      cyc(2);
      `CHK("therm released", 1'b0, thermLineOe)
    end
    `CHK("irq", 1'b1, irq)
    rd(8'h40, 32'h03);
    wr(8'h44, 8'h00);
    cyc(1);
    `CHK("irq masked", 1'b0, irq)
    wr(8'h44, 8'h01);
    wr(8'h40, 8'h03);
    cyc(1);
    `CHK("irq cleared", 1'b0, irq)
    // a cell beyond the configured count is ignored
    wr(8'h04, 8'hc0);
    setCell(3'h7, 16'h10cc);
    cyc(30);
    `CHK("unused cell", 1'b0, highCellFault)
    setCell(3'h7, 16'h0bb8);
    wr(8'h04, 8'h40);
    // low fault recovery with and without hysteresis
    setCell(3'h0, 16'h07cf);
    cyc(3);
    `CHK("low fault", 1'b1, lowCellFault)
    rd(8'h48, 32'h02);
    setCell(3'h0, 16'h0834);
    cyc(3);
    `CHK("low held", 1'b1, lowCellFault)
    wr(8'h10, 8'h86);
    cyc(3);
    `CHK("low released", 1'b0, lowCellFault)
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
